// ### inc/rsf_defines.svh
// Purpose: Constants of the receive framing sideband
// Assumes: Included by bare name
// Notes:   Definitions only
`ifndef RSF_DEFINES_SVH
`define RSF_DEFINES_SVH

`define RSF_KEEP_ALL      8'hFF
`define RSF_KEEP_LOW      8'h0F
`define RSF_SOF_LSB       10
`define RSF_SOF_MSB       14
`define RSF_EOF_LSB       17
`define RSF_EOF_MSB       21
`define RSF_USER_W        22
`define RSF_SOF_BYTE0     5'h10
`define RSF_SOF_BYTE8     5'h18
`define RSF_SOF_NONE      5'h00
`define RSF_EOF_BYTE3     5'h13
`define RSF_EOF_BYTE7     5'h17
`define RSF_EOF_BYTE11    5'h1B
`define RSF_EOF_BYTE15    5'h1F
`define RSF_EOF_NONE      5'h0F

`endif

// ### inc/rsf_pkg.sv
// Purpose: Types of the receive framing sideband
// Assumes: Nothing
// Notes:   Constants live in rsf_defines.svh
`default_nettype none
package rsf_pkg;
    typedef enum logic {RSF_EMPTY, RSF_LOWER} rsf_lane_t;
    typedef struct packed {
        logic [63:0] data;
        logic        last;
        logic        half;
    } rsf_qword_t;
endpackage
`default_nettype wire

// ### inc/rsf_stream_if.sv
// Purpose: Valid/ready carrier between framer and its buffer
// Assumes: Single clock
// Notes:   Payload width is a parameter
`default_nettype none
interface rsf_stream_if #(
    parameter int W = 66
);
    logic [W-1:0] data;
    logic         valid;
    logic         ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// ### rtl/rsf_skid_buf.sv
// Purpose: Two-entry buffer with registered ready on the fill side
// Assumes: Asynchronous active-low reset, released in step with the clock
// Notes:   Ready comes from a flop, so a drain stall costs one spare entry
`default_nettype none
module rsf_skid_buf #(
    parameter int W = 66
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // Fill side
    input  wire logic [W-1:0] in_data_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    // Drain side
    rsf_stream_if.src         out_s
);
    logic [W-1:0] main_r;
    logic [W-1:0] main_nxt;
    logic [W-1:0] skid_r;
    logic [W-1:0] skid_nxt;
    logic         main_v_r;
    logic         main_v_nxt;
    logic         skid_v_r;
    logic         skid_v_nxt;
    logic         ready_r;
    logic         push;
    logic         pop;

    always_comb begin
        push       = in_valid_i && ready_r;
        pop        = main_v_r && out_s.ready;
        main_nxt   = main_r;
        skid_nxt   = skid_r;
        main_v_nxt = main_v_r;
        skid_v_nxt = skid_v_r;
        if (pop || !main_v_r) begin
            if (skid_v_r) begin
                main_nxt   = skid_r;
                main_v_nxt = 1'b1;
                skid_v_nxt = 1'b0;
            end else begin
                main_nxt   = in_data_i;
                main_v_nxt = push;
            end
            if (skid_v_r && push) begin
                skid_nxt   = in_data_i;
                skid_v_nxt = 1'b1;
            end
        end else if (push) begin
            // Drain stalled: park the word rather than drop it
            skid_nxt   = in_data_i;
            skid_v_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            main_r   <= '0;
            skid_r   <= '0;
            main_v_r <= 1'b0;
            skid_v_r <= 1'b0;
            ready_r  <= 1'b0;
        end else begin
            main_r   <= main_nxt;
            skid_r   <= skid_nxt;
            main_v_r <= main_v_nxt;
            skid_v_r <= skid_v_nxt;
            ready_r  <= !skid_v_nxt;
        end
    end

    assign in_ready_o  = ready_r;
    assign out_s.data  = main_r;
    assign out_s.valid = main_v_r;
endmodule
`default_nettype wire

// ### rtl/rsf_rx_framer.sv
// Purpose: Receive stream framer driving keep or start/end sideband
// Assumes: Quadword packet stream from the core on the same clock
// Notes:   DATA_W selects the 64-bit or 128-bit user port
//
// Summary of operation
// - Keep bit n marks byte n valid
// - Keep all ones on non-final beats
// - Final keep only 0x0F or 0xFF
// - 128-bit packets start in either quadword
// - Start field bits 14:10, end 21:17
// - Start top bit flags start, low bits position
// - Start codes 10000 byte0, 11000 byte8
// - No start gives all zeros
// - End top bit flags end, low bits position
// - End codes 10011 byte3, 10111 byte7
// - End codes 11011 byte11, 11111 byte15
// - No end gives 01111
// - Beat moves when valid and ready
`include "rsf_defines.svh"
`default_nettype none
module rsf_rx_framer
    import rsf_pkg::*;
#(
    parameter int DATA_W = 128
) (
    // Clock and reset
    input  wire logic              ref_clk_i,
    input  wire logic              arst_n_i,
    // Packet stream from the core
    input  wire logic [63:0]       in_data_i,
    input  wire logic              in_last_i,
    input  wire logic              in_half_i,
    input  wire logic              in_valid_i,
    output logic                   in_ready_o,
    // User receive port
    output logic [DATA_W-1:0]      rx_data_o,
    output logic [7:0]             rx_keep_o,
    output logic                   rx_last_o,
    output logic [`RSF_USER_W-1:0] rx_user_o,
    output logic                   rx_valid_o,
    input  wire logic              rx_ready_i
);
    localparam bit WIDE = (DATA_W == 128);

    logic                   rst_s1_r;
    logic                   rst_n_r;
    rsf_qword_t             q;
    logic                   out_free;
    logic                   take;
    rsf_lane_t              lane_r;
    rsf_lane_t              lane_nxt;
    logic [63:0]            lo_data_r;
    logic [63:0]            lo_data_nxt;
    logic                   lo_sof_r;
    logic                   lo_sof_nxt;
    logic                   lo_eof_r;
    logic                   lo_eof_nxt;
    logic                   lo_half_r;
    logic                   lo_half_nxt;
    logic                   in_pkt_r;
    logic                   in_pkt_nxt;
    logic [DATA_W-1:0]      data_r;
    logic [DATA_W-1:0]      data_nxt;
    logic [7:0]             keep_r;
    logic [7:0]             keep_nxt;
    logic                   last_r;
    logic                   last_nxt;
    logic [4:0]             sof_r;
    logic [4:0]             sof_nxt;
    logic [4:0]             eof_r;
    logic [4:0]             eof_nxt;
    logic                   valid_r;
    logic                   valid_nxt;
    logic [127:0]           wide_word;

    rsf_stream_if #(.W($bits(rsf_qword_t))) buf_s ();

    // Reset release through two flops
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    rsf_skid_buf #(
        .W          ($bits(rsf_qword_t))
    ) u_buf (
        .clk_i      (ref_clk_i),
        .rst_n_i    (rst_n_r),
        .in_data_i  ({in_data_i, in_last_i, in_half_i}),
        .in_valid_i (in_valid_i),
        .in_ready_o (in_ready_o),
        .out_s      (buf_s.src)
    );

    // End code for a lane: upper lane sets bit 3, full qword sets bit 2
    function automatic logic [4:0] eof_code(input logic upper, input logic half);
        logic [4:0] c;
        c = {1'b1, upper, 3'h3};
        c[2] = !half;
        return c;
    endfunction

    // Keep mask of a 64-bit beat
    function automatic logic [7:0] keep_code(input logic last, input logic half);
        return (last && half) ? `RSF_KEEP_LOW : `RSF_KEEP_ALL;
    endfunction

    assign q          = rsf_qword_t'(buf_s.data);
    assign buf_s.ready = take;

    always_comb begin
        // beat moves on valid and ready
        out_free    = !valid_r || rx_ready_i;
        take        = 1'b0;
        lane_nxt    = lane_r;
        lo_data_nxt = lo_data_r;
        lo_sof_nxt  = lo_sof_r;
        lo_eof_nxt  = lo_eof_r;
        lo_half_nxt = lo_half_r;
        in_pkt_nxt  = in_pkt_r;
        data_nxt    = data_r;
        keep_nxt    = keep_r;
        last_nxt    = last_r;
        sof_nxt     = sof_r;
        eof_nxt     = eof_r;
        valid_nxt   = valid_r && !rx_ready_i;
        wide_word   = '0;
        if (!WIDE) begin
            if (buf_s.valid && out_free) begin
                take      = 1'b1;
                data_nxt  = DATA_W'(q.data);
                keep_nxt  = keep_code(q.last, q.half);
                last_nxt  = q.last;
                sof_nxt   = `RSF_SOF_NONE;
                eof_nxt   = `RSF_EOF_NONE;
                valid_nxt = 1'b1;
            end
        end else begin
            case (lane_r)
                RSF_EMPTY: begin
                    if (buf_s.valid) begin
                        take        = 1'b1;
                        lo_data_nxt = q.data;
                        lo_sof_nxt  = !in_pkt_r;
                        lo_eof_nxt  = q.last;
                        lo_half_nxt = q.half;
                        in_pkt_nxt  = !q.last;
                        lane_nxt    = RSF_LOWER;
                    end
                end
                RSF_LOWER: begin
                    // A tail waits for the next qword: pairing is timing-free, at some latency
                    if (out_free && ((lo_eof_r && lo_sof_r) || buf_s.valid)) begin
                        wide_word[63:0] = lo_data_r;
                        sof_nxt         = lo_sof_r ? `RSF_SOF_BYTE0 : `RSF_SOF_NONE;
                        eof_nxt         = `RSF_EOF_NONE;
                        if (lo_eof_r) begin
                            eof_nxt = eof_code(1'b0, lo_half_r);
                            // straddle: next packet opens upper lane
                            if (!lo_sof_r && buf_s.valid && !q.last) begin
                                take              = 1'b1;
                                wide_word[127:64] = q.data;
                                sof_nxt           = `RSF_SOF_BYTE8;
                                in_pkt_nxt        = 1'b1;
                            end
                        end else begin
                            take              = 1'b1;
                            wide_word[127:64] = q.data;
                            in_pkt_nxt        = !q.last;
                            if (q.last) begin
                                eof_nxt = eof_code(1'b1, q.half);
                            end
                        end
                        data_nxt  = DATA_W'(wide_word);
                        keep_nxt  = `RSF_KEEP_ALL;
                        last_nxt  = eof_nxt[4];
                        valid_nxt = 1'b1;
                        lane_nxt  = RSF_EMPTY;
                    end
                end
                default: begin
                    lane_nxt = RSF_EMPTY;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            lane_r    <= RSF_EMPTY;
            lo_data_r <= '0;
            lo_sof_r  <= 1'b0;
            lo_eof_r  <= 1'b0;
            lo_half_r <= 1'b0;
            in_pkt_r  <= 1'b0;
            data_r    <= '0;
            keep_r    <= `RSF_KEEP_ALL;
            last_r    <= 1'b0;
            sof_r     <= `RSF_SOF_NONE;
            eof_r     <= `RSF_EOF_NONE;
            valid_r   <= 1'b0;
        end else begin
            lane_r    <= lane_nxt;
            lo_data_r <= lo_data_nxt;
            lo_sof_r  <= lo_sof_nxt;
            lo_eof_r  <= lo_eof_nxt;
            lo_half_r <= lo_half_nxt;
            in_pkt_r  <= in_pkt_nxt;
            data_r    <= data_nxt;
            keep_r    <= keep_nxt;
            last_r    <= last_nxt;
            sof_r     <= sof_nxt;
            eof_r     <= eof_nxt;
            valid_r   <= valid_nxt;
        end
    end

    always_comb begin
        rx_user_o = '0;
        if (WIDE) begin
            rx_user_o[`RSF_SOF_MSB:`RSF_SOF_LSB] = sof_r;
            rx_user_o[`RSF_EOF_MSB:`RSF_EOF_LSB] = eof_r;
        end
    end

    assign rx_data_o  = data_r;
    assign rx_keep_o  = keep_r;
    assign rx_last_o  = last_r;
    assign rx_valid_o = valid_r;

    // Straddled beats are emitted only when the lower packet is a tail,
    // so one beat never carries two starts or two ends.

    // Helper: last quadword taken in narrow mode, for the keep check
    logic [63:0] last_qword_r;
    always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            last_qword_r <= '0;
        end else if (take && !WIDE) begin
            last_qword_r <= q.data;
        end
    end

    keep_mid_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_r)
        rx_valid_o && !rx_last_o |-> rx_keep_o == `RSF_KEEP_ALL)
        else $error("keep not all ones mid packet");

    keep_last_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_r)
        rx_valid_o && rx_last_o |-> rx_keep_o inside {`RSF_KEEP_LOW, `RSF_KEEP_ALL})
        else $error("illegal final keep");

    keep_bytes_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_r)
        rx_valid_o && !WIDE |-> rx_keep_o[7:4] == '0 ?
            (rx_keep_o[3:0] == 4'hF && data_r == DATA_W'(last_qword_r)) : 1'b1)
        else $error("keep low mask does not mark low bytes");

    sof_codes_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_r)
        rx_valid_o && WIDE |-> sof_r inside {`RSF_SOF_BYTE0, `RSF_SOF_BYTE8, `RSF_SOF_NONE})
        else $error("illegal start code");

    sof_flag_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_r)
        rx_valid_o && WIDE && !sof_r[4] |-> sof_r == `RSF_SOF_NONE)
        else $error("start position without flag");

    sof_upper_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_r)
        rx_valid_o && sof_r == `RSF_SOF_BYTE8 |-> eof_r[4] && !eof_r[3])
        else $error("upper start without lower end");

    eof_codes_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_r)
        rx_valid_o && WIDE && eof_r[4] |-> eof_r[1:0] == 2'h3 && rx_last_o)
        else $error("illegal end code");

    eof_none_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_r)
        rx_valid_o && WIDE && !eof_r[4] |-> eof_r == `RSF_EOF_NONE && !rx_last_o)
        else $error("idle end code wrong");

    eof_upper_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_r)
        rx_valid_o && WIDE && eof_r[4] && eof_r[3] |-> sof_r != `RSF_SOF_BYTE8)
        else $error("upper end shares beat with upper start");

    user_bits_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_r)
        rx_user_o[9:0] == '0 && rx_user_o[16:15] == '0)
        else $error("sideband bits outside fields set");

    hold_stall_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_r)
        rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o) && $stable(rx_user_o)
            && $stable(rx_keep_o) && $stable(rx_last_o))
        else $error("beat changed while stalled");
endmodule
`default_nettype wire

// ### bench/rsf_user_sink.sv
// Purpose: User logic that consumes the receive port
// Assumes: Same clock as the framer
// Notes:   Ready is random per cycle; zero percent stalls the port completely
`default_nettype none
module rsf_user_sink #(
    parameter int DATA_W = 128
) (
    // Clock
    input  wire logic              clk_i,
    // Receive port
    input  wire logic [DATA_W-1:0] rx_data_i,
    input  wire logic [7:0]        rx_keep_i,
    input  wire logic              rx_last_i,
    input  wire logic [21:0]       rx_user_i,
    input  wire logic              rx_valid_i,
    output logic                   rx_ready_o,
    // Stall control
    input  wire logic [6:0]        ready_pct_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [158:0] got_q[$];
    logic         ready_r = 1'b0;
    assign rx_ready_o = ready_r;
    // beat taken on valid and ready
    // whole beat kept, bytes past end judged by the bench
    always @(posedge clk_i) begin
        if (rx_valid_i === 1'b1 && rx_ready_o === 1'b1) begin
            got_q.push_back({128'(rx_data_i), rx_keep_i, rx_last_i, rx_user_i});
        end
        #1 ready_r <= ($urandom_range(99) < ready_pct_i);
    end
endmodule
`default_nettype wire

// ### bench/rsf_rx_framer_tb.sv
// Purpose: Self-checking bench for both port widths of the receive framer
// Assumes: One word stream feeds both instances, held until both take it
// Notes:   Beats are compared after the run; bytes past the end are masked
`default_nettype none
module rsf_rx_framer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TMO = 300;
    logic         ref_clk_i;
    logic         arst_n_i;
    logic [63:0]  in_data_i;
    logic         in_last_i;
    logic         in_half_i;
    logic [1:0]   in_valid_i;
    logic [6:0]   pct;
    wire  [1:0]   in_ready_o;
    wire  [1:0]   rx_valid_o;
    wire  [1:0]   rx_last_o;
    wire  [1:0]   rx_ready_i;
    wire  [63:0]  rx_data64;
    wire  [127:0] rx_data128;
    wire  [7:0]   keep64;
    wire  [7:0]   keep128;
    wire  [21:0]  user64;
    wire  [21:0]  user128;
    logic [158:0] exp64_q[$];
    logic [158:0] exp128_q[$];
    logic [15:0]  msk_q[$];
    logic         pend;
    logic         pl;
    logic         ph;
    logic         pf;
    logic         is_first;
    logic [63:0]  pw;
    int           fails;
    int           check_count;
    int           lens[10] = '{1, 1, 3, 2, 1, 3, 3, 2, 2, 1};

    rsf_rx_framer #(.DATA_W(64)) i_rsf_rx_framer_w64 (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
        .in_data_i(in_data_i), .in_last_i(in_last_i), .in_half_i(in_half_i), .in_valid_i(in_valid_i[0]),
        .in_ready_o(in_ready_o[0]), .rx_data_o(rx_data64), .rx_keep_o(keep64), .rx_last_o(rx_last_o[0]),
        .rx_user_o(user64), .rx_valid_o(rx_valid_o[0]), .rx_ready_i(rx_ready_i[0]));
    rsf_rx_framer #(.DATA_W(128)) i_rsf_rx_framer (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
        .in_data_i(in_data_i), .in_last_i(in_last_i), .in_half_i(in_half_i), .in_valid_i(in_valid_i[1]),
        .in_ready_o(in_ready_o[1]), .rx_data_o(rx_data128), .rx_keep_o(keep128), .rx_last_o(rx_last_o[1]),
        .rx_user_o(user128), .rx_valid_o(rx_valid_o[1]), .rx_ready_i(rx_ready_i[1]));
    rsf_user_sink #(.DATA_W(64)) i_rsf_user_sink_w64 (.clk_i(ref_clk_i), .rx_data_i(rx_data64),
        .rx_keep_i(keep64), .rx_last_i(rx_last_o[0]), .rx_user_i(user64), .rx_valid_i(rx_valid_o[0]),
        .rx_ready_o(rx_ready_i[0]), .ready_pct_i(pct));
    rsf_user_sink #(.DATA_W(128)) i_rsf_user_sink (.clk_i(ref_clk_i), .rx_data_i(rx_data128),
        .rx_keep_i(keep128), .rx_last_i(rx_last_o[1]), .rx_user_i(user128), .rx_valid_i(rx_valid_o[1]),
        .rx_ready_o(rx_ready_i[1]), .ready_pct_i(pct));

    always #4 ref_clk_i = ~ref_clk_i;

    task automatic final_report;
        if (fails == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic cmp(input logic [127:0] g, input logic [127:0] e, input string what);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("wrong value at %0t: %s got %0h exp %0h", $time, what, g, e);
        end
    endtask

    function automatic logic [127:0] bmask(input logic [15:0] m);
        for (int b = 0; b < 16; b++) bmask[8*b+:8] = {8{m[b]}};
    endfunction

    task automatic push128(input logic [127:0] d, input logic [4:0] s, input logic [4:0] e, input logic [15:0] m);
        exp128_q.push_back({d, 8'hFF, e[4], e, 2'b00, s, 10'h000});
        msk_q.push_back(m);
    endtask

    // Lower quadword waits for its partner unless it is a whole one-quadword packet; a waiting tail straddles with a new non-final start
    task automatic expect_word(input logic [63:0] d, input logic l, input logic h);
        exp64_q.push_back({64'h0, d, (l && h) ? 8'h0F : 8'hFF, l, 22'h000000});
        if (pend && pl && !l) begin
            push128({d, pw}, 5'h18, ph ? 5'h13 : 5'h17, ph ? 16'hFF0F : 16'hFFFF);
            pend = 1'b0;
        end else if (pend && !pl) begin
            push128({d, pw}, pf ? 5'h10 : 5'h00, l ? (h ? 5'h1B : 5'h1F) : 5'h0F, (l && h) ? 16'h0FFF : 16'hFFFF);
            pend = 1'b0;
        end else begin
            if (pend) push128({64'h0, pw}, 5'h00, ph ? 5'h13 : 5'h17, ph ? 16'h000F : 16'h00FF);
            pend = !(l && is_first);
            if (!pend) push128({64'h0, d}, 5'h10, h ? 5'h13 : 5'h17, h ? 16'h000F : 16'h00FF);
            {pw, pl, ph, pf} = {d, l, h, is_first};
        end
        is_first = l;
    endtask

    task automatic send_word(input logic [63:0] d, input logic l, input logic h);
        logic [1:0] left;
        expect_word(d, l, h);
        {in_data_i, in_last_i, in_half_i, in_valid_i} = {d, l, h, 2'b11};
        left = 2'b11;
        // Valid is only lowered here while a word is still owed; the next call raises it
        for (int n = 0; n < TMO && left !== 2'b00; n++) begin
            @(posedge ref_clk_i);
            left = left & ~in_ready_o;
            #1;
            if (left !== 2'b00) in_valid_i = left;
        end
        if (left !== 2'b00) begin
            fails++;
            $display("wrong value at %0t: input word never taken", $time);
            final_report();
        end
    endtask

    task automatic send_pkt(input int len);
        for (int k = 1; k <= len; k++) send_word({$urandom, $urandom}, k == len, k == len && $urandom_range(1));
    endtask

    initial begin
        logic [158:0] g;
        logic [158:0] e;
        logic [127:0] bm;
        void'($urandom(81));
        {ref_clk_i, arst_n_i, in_data_i, in_last_i, in_half_i, in_valid_i, pct} = '0;
        {pend, pl, ph, pf, pw, is_first, fails, check_count} = '0;
        is_first = 1'b1;
        repeat (2) @(posedge ref_clk_i);
        #1;
        cmp(128'({rx_valid_o, in_ready_o}), 128'h0, "reset handshake");
        cmp(128'(user128), 128'h1E0000, "reset sideband");
        @(posedge ref_clk_i);
        #1 arst_n_i = 1'b1;
        repeat (3) @(posedge ref_clk_i);
        #1;
        fork
            begin
                repeat (40) @(posedge ref_clk_i);
                #2;
                cmp(128'(in_ready_o), 128'h0, "ready while stalled");
                cmp(128'(rx_valid_o), 128'h3, "beat held while stalled");
                pct = 7'd50;
            end
        join_none
        foreach (lens[i]) send_pkt(lens[i]);
        pct = 7'd100;
        repeat (10) send_pkt(1 + $urandom_range(3));
        pct = 7'd30;
        repeat (30) send_pkt(1 + $urandom_range(4));
        pct = 7'd100;
        send_pkt(1);
        in_valid_i = 2'b00;
        for (int n = 0; n < TMO && (i_rsf_user_sink.got_q.size() < exp128_q.size()
                || i_rsf_user_sink_w64.got_q.size() < exp64_q.size()); n++) @(posedge ref_clk_i);
        cmp(128'(i_rsf_user_sink_w64.got_q.size()), 128'(exp64_q.size()), "beats 64");
        cmp(128'(i_rsf_user_sink.got_q.size()), 128'(exp128_q.size()), "beats 128");
        foreach (exp64_q[i]) begin
            if (i >= i_rsf_user_sink_w64.got_q.size()) break;
            g = i_rsf_user_sink_w64.got_q[i];
            e = exp64_q[i];
            bm = bmask({8'h00, e[30:23]});
            cmp(g[158:31] & bm, e[158:31] & bm, "data 64");
            cmp(128'(g[30:23]), 128'(e[30:23]), "keep 64");
            cmp(128'(g[22:0]), 128'(e[22:0]), "last 64");
        end
        foreach (exp128_q[i]) begin
            if (i >= i_rsf_user_sink.got_q.size()) break;
            g = i_rsf_user_sink.got_q[i];
            e = exp128_q[i];
            bm = bmask(msk_q[i]);
            cmp(g[158:31] & bm, e[158:31] & bm, "data 128");
            cmp(128'(g[14:10]), 128'(e[14:10]), "start 128");
            cmp(128'(g[21:17]), 128'(e[21:17]), "end 128");
            cmp(128'(g[30:0]), 128'(e[30:0]), "keep last user 128");
        end
        final_report();
    end
endmodule
`default_nettype wire
